// ### hvr_camac_regs.v
// dataway register block of a one- or two-channel high-voltage supply
`include "hvr_consts.vh"

// What this block does
// - event bits latch and stay set
// - event read returns bits, then clears all but events set in that cycle
// - tripped channel refuses set voltage until event read
// - identifier word is six bcd digits
// - limits word: voltage mantissa and exponent high
// - limits word: current mantissa and exponent low
// - auto-start read shows bits r12 and r04
// - auto-start write ramps when channel is clean
// - save bits store settings, reloaded at power-on
// - first read answers q low, repeat gets data
// - measurement frozen 400 ms after being read
// - status error is or of the trip, range, inhibit, overload and quality events
module hvr_camac_regs #(
    parameter DATA_W      = 24,
    parameter IDENT_WORD  = 24'h123456,  // arbitrary bcd value
    parameter PREP_CYCLES = `HVR_PREP_US * `HVR_CLK_MHZ,
    parameter HOLD_CYCLES = `HVR_HOLD_MS * 1000 * `HVR_CLK_MHZ
) (
    input  wire              clk,
    input  wire              nrst,
    input  wire              ce,              // freezes all state when low
    input  wire              dw_station,      // station select n
    input  wire              dw_strobe1,      // s1 strobe
    input  wire              dw_strobe2,      // s2 strobe
    input  wire              dw_zero,         // z, general reset with s2
    input  wire [3:0]        dw_sub_addr,     // a
    input  wire [4:0]        dw_func,         // f
    input  wire [DATA_W-1:0] dw_write,        // w lines
    output reg  [DATA_W-1:0] dw_read,         // r lines
    output reg               dw_q,            // q answer
    output reg               dw_x,            // command accepted
    input  wire [15:0]       event_set,       // event pulses, one per bit
    input  wire [15:0]       switch_status,   // front panel and ramp state
    input  wire [DATA_W-1:0] meas_volt_a,     // converter results
    input  wire [DATA_W-1:0] meas_volt_b,
    input  wire [DATA_W-1:0] meas_curr_a,
    input  wire [DATA_W-1:0] meas_curr_b,
    input  wire [7:0]        vmax_mant_a,     // channel limits
    input  wire [3:0]        vmax_exp_a,
    input  wire [7:0]        imax_mant_a,
    input  wire [3:0]        imax_exp_a,
    input  wire [7:0]        vmax_mant_b,
    input  wire [3:0]        vmax_exp_b,
    input  wire [7:0]        imax_mant_b,
    input  wire [3:0]        imax_exp_b,
    input  wire [DATA_W-1:0] nv_set_voltage_a, // stored values at power-on
    input  wire [DATA_W-1:0] nv_set_voltage_b,
    input  wire [1:0]        nv_autostart,
    output wire [DATA_W-1:0] set_voltage_a,   // setting outputs
    output wire [DATA_W-1:0] set_voltage_b,
    output wire [DATA_W-1:0] ramp_rate_a,
    output wire [DATA_W-1:0] ramp_rate_b,
    output wire [DATA_W-1:0] trip_level_a,
    output wire [DATA_W-1:0] trip_level_b,
    output reg  [1:0]        start_ramp,      // pulse per channel, b is bit 1
    output reg  [5:0]        nv_save,         // pulse, b in [5:3], a in [2:0]
    output reg  [1:0]        autostart,       // auto-start active per channel
    output reg  [15:0]       event_reg        // latched events
);

// ----------------------------------------
// input synchronisers
// ----------------------------------------
wire [`HVR_SYNC_W-1:0] raw_in = {dw_station, dw_strobe1, dw_strobe2, dw_zero,
                                 dw_sub_addr, dw_func, dw_write};
reg  [`HVR_SYNC_W-1:0] sync_a;             // first stage, read by sync_b only
reg  [`HVR_SYNC_W-1:0] sync_b;             // second stage
reg  [`HVR_SYNC_W-1:0] sync_c;             // third stage
reg  [`HVR_SYNC_W-1:0] sync_q;             // agreed value

genvar gi;
generate
    for (gi = 0; gi < `HVR_SYNC_W; gi = gi + 1) begin : g_sync
        // a change counts once stages two and three agree
        always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                sync_a[gi] <= 1'b0;
                sync_b[gi] <= 1'b0;
                sync_c[gi] <= 1'b0;
                sync_q[gi] <= 1'b0;
            end else if (ce) begin
                sync_a[gi] <= raw_in[gi];
                sync_b[gi] <= sync_a[gi];
                sync_c[gi] <= sync_b[gi];
                if (sync_b[gi] == sync_c[gi])
                    sync_q[gi] <= sync_c[gi];
            end
        end
    end
endgenerate

wire              s_station = sync_q[36];  // synchronised dataway lines
wire              s_strobe1 = sync_q[35];
wire              s_strobe2 = sync_q[34];
wire              s_zero    = sync_q[33];
wire [3:0]        s_addr    = sync_q[32:29];
wire [4:0]        s_func    = sync_q[28:24];
wire [DATA_W-1:0] s_write   = sync_q[DATA_W-1:0];

reg  station_d;                            // edge detection
reg  strobe1_d;
reg  strobe2_d;
wire cmd_begin = s_station & ~station_d;
wire cmd_act   = s_strobe1 & ~strobe1_d & s_station;
wire gen_reset = s_zero & s_strobe2 & ~strobe2_d;

// ----------------------------------------
// decoding
// ----------------------------------------
// settings word index, or 7 when the sub-address holds no setting
function [2:0] ctl_index;
    input [3:0] a;
    begin
        case (a)
            4'h0: ctl_index = 3'h0;
            4'h1: ctl_index = 3'h1;
            4'h2: ctl_index = 3'h2;
            4'h3: ctl_index = 3'h3;
            4'ha: ctl_index = 3'h4;
            4'hb: ctl_index = 3'h5;
            default: ctl_index = 3'h7;
        endcase
    end
endfunction

// ----------------------------------------
// settings, events, measurement snapshots
// ----------------------------------------
reg  [DATA_W-1:0] ctl [0:5];               // set voltage, ramp, trip words
reg  [DATA_W-1:0] snap [0:3];              // held measurements
reg  [31:0]       hold_cnt [0:3];          // refresh hold per measurement
wire [DATA_W-1:0] meas_raw [0:3];
assign meas_raw[0] = meas_volt_a;
assign meas_raw[1] = meas_volt_b;
assign meas_raw[2] = meas_curr_a;
assign meas_raw[3] = meas_curr_b;
assign set_voltage_a = ctl[0];
assign set_voltage_b = ctl[1];
assign ramp_rate_a   = ctl[2];
assign ramp_rate_b   = ctl[3];
assign trip_level_a  = ctl[4];
assign trip_level_b  = ctl[5];

wire [1:0] locked;                          // channel refuses new set voltage
wire [1:0] ch_error;                        // status error per channel
wire [1:0] as_ok;                           // auto-start allowed
wire [15:0] status_word;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
        localparam B = gi * `HVR_CH_STRIDE;
        assign locked[gi] = event_reg[B + `HVR_EV_OVL] | event_reg[B + `HVR_EV_INH]
                          | event_reg[B + `HVR_EV_TRIP];
        assign ch_error[gi] = locked[gi] | event_reg[B + `HVR_EV_REGQ]
                            | event_reg[B + `HVR_EV_RANGE];
        assign as_ok[gi] = ~switch_status[B + `HVR_ST_ONOFF]
                         & ~switch_status[B + `HVR_ST_SRC]
                         & ~event_reg[B + `HVR_EV_REGQ] & ~locked[gi];
    end
endgenerate
assign status_word = {ch_error[1], switch_status[14:8],
                      ch_error[0], switch_status[6:0]};

// ----------------------------------------
// read value selection
// ----------------------------------------
reg  [DATA_W-1:0] next_rd;                 // value for the current address
reg               next_known;              // command is implemented
reg               next_is_read;
always @* begin
    next_rd      = {DATA_W{1'b0}};
    next_known   = 1'b0;
    next_is_read = 1'b0;
    case (s_func)
        `HVR_F_RD0: begin
            next_is_read = 1'b1;
            next_known   = 1'b1;
            if (ctl_index(s_addr) != 3'h7)
                next_rd = ctl[ctl_index(s_addr)];
            else if (s_addr >= `HVR_A_MEAS_LO && s_addr <= `HVR_A_MEAS_HI)
                next_rd = snap[s_addr[1:0]];
            else if (s_addr == `HVR_A_LIM_A)
                next_rd = {vmax_mant_a, vmax_exp_a, imax_mant_a, imax_exp_a};
            else if (s_addr == `HVR_A_LIM_B)
                next_rd = {vmax_mant_b, vmax_exp_b, imax_mant_b, imax_exp_b};
            else
                next_known = 1'b0;
        end
        `HVR_F_RD1: begin
            next_is_read = 1'b1;
            next_known   = 1'b1;
            case (s_addr)
                `HVR_A_STATUS: next_rd = {8'h00, status_word};
                `HVR_A_AUTO:   next_rd = {12'h000, autostart[1], 7'h00,
                                          autostart[0], 3'h0};
                `HVR_A_EVENT:  next_rd = {8'h00, event_reg};
                `HVR_A_IDENT:  next_rd = IDENT_WORD;
                default:       next_known = 1'b0;
            endcase
        end
        `HVR_F_WR16: next_known = (ctl_index(s_addr) != 3'h7);
        `HVR_F_WR17: next_known = (s_addr == `HVR_A_AUTO);
        `HVR_F_START: next_known = (s_addr[3:1] == 3'h0);
        default: next_known = 1'b0;
    endcase
end

// ----------------------------------------
// command answer and read preparation
// ----------------------------------------
reg [8:0]  prep_cmd;                       // command being prepared
reg        prep_ready;                     // prepared data may be delivered
reg [31:0] prep_cnt;                       // preparation time left
reg        loaded;                         // power-on values taken
integer    k;

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        station_d  <= 1'b0;
        strobe1_d  <= 1'b0;
        strobe2_d  <= 1'b0;
        dw_read    <= {DATA_W{1'b0}};
        dw_q       <= 1'b0;
        dw_x       <= 1'b0;
        prep_cmd   <= 9'h000;
        prep_ready <= 1'b0;
        prep_cnt   <= 32'h0;
        event_reg  <= 16'h0000;
        autostart  <= 2'b00;
        start_ramp <= 2'b00;
        nv_save    <= 6'h00;
        loaded     <= 1'b0;
        for (k = 0; k < 6; k = k + 1)
            ctl[k] <= {DATA_W{1'b0}};
        for (k = 0; k < 4; k = k + 1) begin
            snap[k]     <= {DATA_W{1'b0}};
            hold_cnt[k] <= 32'h0;
        end
    end else if (ce) begin
        station_d  <= s_station;
        strobe1_d  <= s_strobe1;
        strobe2_d  <= s_strobe2;
        start_ramp <= 2'b00;
        nv_save    <= 6'h00;
        // stored settings enter the registers once after power-on
        if (!loaded) begin
            loaded    <= 1'b1;
            ctl[0]    <= nv_set_voltage_a;
            ctl[1]    <= nv_set_voltage_b;
            autostart <= nv_autostart;
        end
        // measurement snapshots follow the converter unless held
        for (k = 0; k < 4; k = k + 1) begin
            if (hold_cnt[k] != 32'h0)
                hold_cnt[k] <= hold_cnt[k] - 32'h1;
            else
                snap[k] <= meas_raw[k];
        end
        // preparation timer
        if (prep_cnt != 32'h0) begin
            prep_cnt <= prep_cnt - 32'h1;
            if (prep_cnt == 32'h1)
                prep_ready <= 1'b1;
        end
        // answer is set up when the station is addressed
        if (cmd_begin) begin
            dw_x <= next_known;
            if (!next_known) begin
                dw_q    <= 1'b0;
                dw_read <= {DATA_W{1'b0}};
            end else if (!next_is_read) begin
                dw_q    <= 1'b1;
                dw_read <= {DATA_W{1'b0}};
            end else if (prep_ready && prep_cmd == {s_addr, s_func}) begin
                dw_q    <= 1'b1;
                dw_read <= next_rd;
            end else begin
                dw_q       <= 1'b0;
                dw_read    <= {DATA_W{1'b0}};
                prep_cmd   <= {s_addr, s_func};
                prep_ready <= 1'b0;
                prep_cnt   <= PREP_CYCLES;
            end
        end else if (!s_station) begin
            dw_q    <= 1'b0;
            dw_x    <= 1'b0;
            dw_read <= {DATA_W{1'b0}};
        end
        // side effects happen at strobe one of an accepted command
        if (cmd_act && dw_x && next_is_read && dw_q) begin
            prep_ready <= 1'b0;
            if (s_addr >= `HVR_A_MEAS_LO && s_addr <= `HVR_A_MEAS_HI
                && s_func == `HVR_F_RD0)
                hold_cnt[s_addr[1:0]] <= HOLD_CYCLES;
        end
        if (cmd_act && dw_x && s_func == `HVR_F_WR16) begin
            if (s_addr[3:1] != 3'h0 || !locked[s_addr[0]])
                ctl[ctl_index(s_addr)] <= s_write;
        end
        if (cmd_act && dw_x && s_func == `HVR_F_START)
            start_ramp[s_addr[0]] <= 1'b1;
        if (cmd_act && dw_x && s_func == `HVR_F_WR17) begin
            for (k = 0; k < 2; k = k + 1) begin
                autostart[k] <= s_write[k * `HVR_CH_STRIDE + `HVR_AS_START];
                if (s_write[k * `HVR_CH_STRIDE + `HVR_AS_START] && as_ok[k])
                    start_ramp[k] <= 1'b1;
            end
            nv_save <= {s_write[10:8], s_write[2:0]};
        end
        // event register: set wins over clear-on-read
        if (gen_reset) begin
            event_reg  <= event_set;
            prep_ready <= 1'b0;
            prep_cnt   <= 32'h0;
        end else if (cmd_act && dw_x && dw_q && s_func == `HVR_F_RD1
                     && s_addr == `HVR_A_EVENT)
            event_reg <= event_set;
        else
            event_reg <= event_reg | event_set;
    end
end

endmodule // hvr_camac_regs

// ### hvr_camac_regs_properties.sv
// checker of the dataway register block, bound to its ports
`include "hvr_consts.vh"
module hvr_camac_props #(
    parameter IDENT_WORD = 24'h000000
) (
    input wire        clk,
    input wire        nrst,
    input wire        ce,
    input wire [3:0]  dw_sub_addr,
    input wire [4:0]  dw_func,
    input wire [23:0] dw_read,
    input wire        dw_q,
    input wire [15:0] event_set,
    input wire [15:0] event_reg,
    input wire [1:0]  start_ramp,
    input wire [5:0]  nv_save,
    input wire [23:0] set_voltage_a,
    input wire [7:0]  vmax_mant_a,
    input wire [3:0]  vmax_exp_a,
    input wire [7:0]  imax_mant_a,
    input wire [3:0]  imax_exp_a
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_event_latch: assert property (ce |=> (event_reg & $past(event_set)) == $past(event_set))
        else $error("event pulse not latched");
    a_clear_on_read: assert property (|($past(event_reg) & ~event_reg) |-> $past(dw_q)
        && $past(dw_sub_addr) == `HVR_A_EVENT && (event_reg & ~$past(event_set)) == 16'h0000)
        else $error("event bits cleared without a valid event read");
    a_unprep_zero: assert property (!dw_q |-> dw_read == 24'h000000)
        else $error("read lines not zero without q");
    a_locked_set: assert property ($past(|(event_reg & 16'h0062)) |-> $stable(set_voltage_a))
        else $error("set voltage changed while channel locked");
    a_start_pulse: assert property (|start_ramp |-> $past(dw_q) ##1 start_ramp == 2'b00)
        else $error("start pulse without command or too long");
    a_save_pulse: assert property (|nv_save |-> $past(dw_func) == `HVR_F_WR17 ##1 nv_save == 6'h00)
        else $error("save pulse without command or too long");
    a_ident_word: assert property (dw_q && dw_sub_addr == `HVR_A_IDENT |-> dw_read == IDENT_WORD)
        else $error("identifier word wrong");
    a_limits_word: assert property (dw_q && dw_sub_addr == `HVR_A_LIM_A && dw_func == `HVR_F_RD0
        |-> dw_read == {vmax_mant_a, vmax_exp_a, imax_mant_a, imax_exp_a}) else $error("limits word wrong");
    a_status_err: assert property (dw_q && dw_sub_addr == `HVR_A_STATUS && dw_func == `HVR_F_RD1
        |-> dw_read[7] == |(event_reg & 16'h00f2)) else $error("status error bit wrong");
    c_event_read: cover property (dw_q && dw_sub_addr == `HVR_A_EVENT);
    c_start: cover property (|start_ramp);
    c_save: cover property (|nv_save);
endmodule // hvr_camac_props
bind hvr_camac_regs hvr_camac_props #(.IDENT_WORD(IDENT_WORD)) u_props (
    .clk(clk), .nrst(nrst), .ce(ce), .dw_sub_addr(dw_sub_addr), .dw_func(dw_func),
    .dw_read(dw_read), .dw_q(dw_q), .event_set(event_set), .event_reg(event_reg),
    .start_ramp(start_ramp), .nv_save(nv_save), .set_voltage_a(set_voltage_a),
    .vmax_mant_a(vmax_mant_a), .vmax_exp_a(vmax_exp_a), .imax_mant_a(imax_mant_a),
    .imax_exp_a(imax_exp_a)
);

// ### hvr_camac_regs_test.sv
// self-checking bench of the dataway register block
`include "hvr_consts.vh"
module hvr_camac_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] IDENT = 24'h205317;  // arbitrary bcd value
    logic        clk = 1'b0, nrst = 1'b0, dw_station, dw_strobe1, dw_q, dw_x, q0, q, x;
    logic [3:0]  dw_sub_addr, vmax_exp_a, imax_exp_a, vmax_exp_b, imax_exp_b;
    logic [4:0]  dw_func;
    logic [7:0]  vmax_mant_a, imax_mant_a, vmax_mant_b, imax_mant_b;
    logic [15:0] event_set, switch_status, event_reg;
    logic [23:0] dw_write, dw_read, meas_volt_a, meas_volt_b, meas_curr_a, meas_curr_b, r0, r, w;
    logic [23:0] nv_set_voltage_a, nv_set_voltage_b, set_voltage_a, set_voltage_b, v1;
    logic [1:0]  nv_autostart, autostart, start_ramp, starts = 2'b00;
    logic [5:0]  nv_save, saves = 6'h00;
    logic [31:0] seed = 32'd85;
    int          bad_count = 0;
    int          n_compared = 0;
    always #5 clk = ~clk;
    // gather one-cycle pulses
    // pulses are only gathered once reset has settled the outputs
    always @(posedge clk) begin
        if (nrst) begin
            starts <= starts | start_ramp;
            saves <= saves | nv_save;
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // status word with error bits made from latched events
    function automatic logic [23:0] stat_exp(logic [15:0] sw, logic [15:0] ev);
        sw[7] = |(ev & 16'h00f2);
        sw[15] = |(ev & 16'hf200);
        return {8'h00, sw};
    endfunction
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // read pair: first answer empty, second holds data
    task automatic rd2(input logic [3:0] a, input logic [4:0] f);
        m.read2(a, f, r0, q0, r, q);
        chk("first q", 24'h0, {23'h0, q0});
        chk("first data", 24'h0, r0);
        chk("second q", 24'h1, {23'h0, q});
    endtask
    hvr_camac_regs #(.IDENT_WORD(IDENT), .PREP_CYCLES(20), .HOLD_CYCLES(200)) dut (
        .clk, .nrst, .ce(1'b1), .dw_station, .dw_strobe1, .dw_strobe2(1'b0), .dw_zero(1'b0),
        .dw_sub_addr, .dw_func, .dw_write, .dw_read, .dw_q, .dw_x, .event_set, .switch_status,
        .meas_volt_a, .meas_volt_b, .meas_curr_a, .meas_curr_b, .vmax_mant_a, .vmax_exp_a,
        .imax_mant_a, .imax_exp_a, .vmax_mant_b, .vmax_exp_b, .imax_mant_b, .imax_exp_b,
        .nv_set_voltage_a, .nv_set_voltage_b, .nv_autostart, .set_voltage_a, .set_voltage_b,
        .ramp_rate_a(), .ramp_rate_b(), .trip_level_a(), .trip_level_b(), .start_ramp,
        .nv_save, .autostart, .event_reg);
    hvr_ctrl_model m (.clk, .dw_station, .dw_strobe1, .dw_sub_addr, .dw_func, .dw_write,
        .dw_read, .dw_q, .dw_x);
    initial begin
        event_set = 16'h0000;
        switch_status = 16'(rnd()) & 16'hf5f5;  // switches on, dac control
        {vmax_mant_a, vmax_exp_a, imax_mant_a, imax_exp_a} = 24'(rnd());
        {vmax_mant_b, vmax_exp_b, imax_mant_b, imax_exp_b} = 24'(rnd());
        meas_volt_a = 24'(rnd());
        meas_volt_b = 24'(rnd());
        meas_curr_a = 24'(rnd());
        meas_curr_b = 24'(rnd());
        nv_set_voltage_a = 24'(rnd());
        nv_set_voltage_b = 24'(rnd());
        nv_autostart = 2'(rnd());
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        chk("nv set voltage", nv_set_voltage_a, set_voltage_a);
        chk("nv set voltage b", nv_set_voltage_b, set_voltage_b);
        chk("nv autostart", {22'h0, nv_autostart}, {22'h0, autostart});
        rd2(`HVR_A_IDENT, `HVR_F_RD1);
        chk("ident", IDENT, r);
        rd2(`HVR_A_LIM_A, `HVR_F_RD0);
        chk("limits a", {vmax_mant_a, vmax_exp_a, imax_mant_a, imax_exp_a}, r);
        rd2(`HVR_A_LIM_B, `HVR_F_RD0);
        chk("limits b", {vmax_mant_b, vmax_exp_b, imax_mant_b, imax_exp_b}, r);
        // trip on a, quality loss on b, both gone again at once
        event_set = 16'h8002;
        @(negedge clk);
        event_set = 16'h0000;
        repeat (4) @(negedge clk);
        chk("event sticky", 24'h008002, {8'h0, event_reg});
        w = 24'(rnd());
        m.cmd(4'h0, `HVR_F_WR16, w, r, q, x);
        chk("locked set", nv_set_voltage_a, set_voltage_a);
        rd2(`HVR_A_STATUS, `HVR_F_RD1);
        chk("status", stat_exp(switch_status, 16'h8002), r);
        m.cmd(`HVR_A_EVENT, `HVR_F_RD1, 24'h0, r, q, x);
        chk("event kept", 24'h008002, {8'h0, event_reg});
        repeat (10) @(negedge clk);
        m.cmd(`HVR_A_EVENT, `HVR_F_RD1, 24'h0, r, q, x);
        chk("event word", 24'h008002, r);
        chk("event cleared", 24'h0, {8'h0, event_reg});
        m.cmd(4'h0, `HVR_F_WR16, w, r, q, x);
        chk("unlocked set", w, set_voltage_a);
        // explicit start of channel b, then a command that is not implemented
        m.cmd(4'h1, `HVR_F_START, 24'h0, r, q, x);
        chk("start b", 24'h2, {22'h0, starts});
        m.cmd(4'hd, `HVR_F_RD1, 24'h0, r, q, x);
        chk("unknown cmd", 24'h0, {23'h0, x | q});
        chk("unknown data", 24'h0, r);
        // start and save both channels in one write
        m.cmd(`HVR_A_AUTO, `HVR_F_WR17, 24'h000f0f, r, q, x);
        chk("start pulses", 24'h3, {22'h0, starts});
        chk("save pulses", 24'h3f, {18'h0, saves});
        rd2(`HVR_A_AUTO, `HVR_F_RD1);
        chk("autostart word", 24'h000808, r);
        v1 = meas_volt_a;
        rd2(`HVR_A_MEAS_LO, `HVR_F_RD0);
        chk("measure", v1, r);
        meas_volt_a = ~v1;
        rd2(`HVR_A_MEAS_LO, `HVR_F_RD0);
        chk("frozen measure", v1, r);
        repeat (250) @(negedge clk);
        rd2(`HVR_A_MEAS_LO, `HVR_F_RD0);
        chk("fresh measure", ~v1, r);
        give_verdict();
    end
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule // hvr_camac_regs_test

// ### hvr_consts.vh
// constants of the high-voltage supply dataway register block
`ifndef HVR_CONSTS_VH
`define HVR_CONSTS_VH
// ----------------------------------------
// dataway function codes
// ----------------------------------------
`define HVR_F_RD0     5'h00
`define HVR_F_RD1     5'h01
`define HVR_F_WR16    5'h10
`define HVR_F_WR17    5'h11
`define HVR_F_START   5'h19
// ----------------------------------------
// sub-addresses
// ----------------------------------------
`define HVR_A_MEAS_LO 4'h4
`define HVR_A_MEAS_HI 4'h7
`define HVR_A_LIM_A   4'h8
`define HVR_A_LIM_B   4'h9
`define HVR_A_STATUS  4'h0
`define HVR_A_AUTO    4'h1
`define HVR_A_EVENT   4'hc
`define HVR_A_IDENT   4'hf
// ----------------------------------------
// event register bit positions (channel a; channel b is +8)
// ----------------------------------------
`define HVR_EV_TRIP   1
`define HVR_EV_INH    5
`define HVR_EV_OVL    6
`define HVR_EV_REGQ   7
`define HVR_EV_RANGE  4
`define HVR_CH_STRIDE 8
// ----------------------------------------
// status word bit positions (channel a; channel b is +8)
// ----------------------------------------
`define HVR_ST_SRC    1
`define HVR_ST_ONOFF  3
`define HVR_ST_ERR    7
// ----------------------------------------
// auto-start word: start bit and save bits (channel a; b is +8)
// ----------------------------------------
`define HVR_AS_START  3
`define HVR_AS_SAVE_LO 0
// ----------------------------------------
// timing
// ----------------------------------------
`define HVR_CLK_MHZ   100
`define HVR_PREP_US   200
`define HVR_HOLD_MS   400
`define HVR_SYNC_W    37
`endif

// ### hvr_ctrl_model.sv
// crate controller model issuing dataway commands
module hvr_ctrl_model (
    input  wire        clk,
    output reg         dw_station  = 1'b0,
    output reg         dw_strobe1  = 1'b0,
    output reg  [3:0]  dw_sub_addr = 4'h0,
    output reg  [4:0]  dw_func     = 5'h00,
    output reg  [23:0] dw_write    = 24'h000000,
    input  wire [23:0] dw_read,
    input  wire        dw_q,
    input  wire        dw_x
);
    timeunit 1ns;
    timeprecision 1ps;
    // one command: select, take answer, strobe, release
    task automatic cmd(input logic [3:0] a, input logic [4:0] f, input logic [23:0] w,
                       output logic [23:0] r, output logic q, output logic x);
        @(negedge clk);
        dw_sub_addr = a;
        dw_func = f;
        dw_write = w;
        dw_station = 1'b1;
        repeat (8) @(negedge clk);
        r = dw_read;
        q = dw_q;
        x = dw_x;
        dw_strobe1 = 1'b1;
        repeat (6) @(negedge clk);
        dw_strobe1 = 1'b0;
        dw_station = 1'b0;
        dw_write = ~w;  // released write lines never keep the last value
        repeat (8) @(negedge clk);
    endtask
    // same command twice, the second after the preparation time
    task automatic read2(input logic [3:0] a, input logic [4:0] f, output logic [23:0] r0,
                         output logic q0, output logic [23:0] r, output logic q);
        logic x;
        cmd(a, f, 24'h000000, r0, q0, x);
        repeat (10) @(negedge clk);
        cmd(a, f, 24'h000000, r, q, x);
    endtask
endmodule // hvr_ctrl_model
